// ---- ilt_core.sv ----
`timescale 1ns/1ps

// Overview of operation
// - Accumulator logic ops: one cycle, 1/2 bytes
// - Immediate logic into direct: three bytes, two cycles
// - Accumulator logic into direct: two bytes, one
// - Single operand accumulator ops: one byte, cycle
// - Register/indirect with direct moves: two, two
// - Direct-direct and immediate-direct moves: three, two
// - Data pointer constant load: three bytes, two
// - Code memory read: one byte, two cycles
// - External RAM moves: one byte, two cycles
// - Push and pop: two bytes, two cycles
// - Exchanges one cycle; nibble exchange one byte
// - Accumulator moved to itself is invalid
// - Bit logic into carry: two, two
// - Carry into bit: two cycles, two bytes
// - Bit into carry: one cycle, two bytes
// - Indirect data pointer jump: one byte, two
// - Bit jump clears bit; three bytes, two
// - Compare jumps: three bytes, two cycles
// - Decrement jump: 2 or 3 bytes, two
// - Conditional relative jumps: two bytes, two cycles
// - Short relative jump: two bytes, two cycles

module ilt_core #(
  parameter int MCYC_CLKS = ilt_pkg::ILT_MCYC_CLKS  // Clocks per cycle
) (
  input  wire logic                          mclk_in,
  input  wire logic                          rst_n_in,
  input  ilt_pkg::ilt_fetch_s                fetch_in,
  output logic                               ready_out,
  output logic [ilt_pkg::ILT_PC_W-1:0]       pc_out,
  output ilt_pkg::ilt_dec_s                  dec_out,
  output logic                               done_out
);
  import ilt_pkg::*;

  // ==========================================================
  // Elaboration check
  if (MCYC_CLKS < 1 || MCYC_CLKS > 65535) begin : g_bad_div
    $error("MCYC_CLKS must lie in 1..65535");
  end

  // ==========================================================
  // Declarations
  ilt_dec_s               dec_now;        // Lookup of offered opcode
  logic [15:0]            div_ff;         // Machine cycle divider
  logic [15:0]            nxt_div;
  logic                   mcyc_en;        // One pulse per machine cycle
  ilt_state_e             state_ff;       // Issue state
  ilt_state_e             nxt_state;
  logic [ILT_CYC_W-1:0]   cnt_ff;         // Machine cycles still due
  logic [ILT_CYC_W-1:0]   nxt_cnt;
  logic [ILT_PC_W-1:0]    pc_ff;          // Next fetch address
  logic [ILT_PC_W-1:0]    nxt_pc;
  ilt_dec_s               dec_ff;         // Instruction in execution
  ilt_dec_s               nxt_dec;
  logic                   ready_ff;       // Free to take an opcode
  logic                   nxt_ready;
  logic                   done_ff;        // Execution finished pulse
  logic                   nxt_done;
  logic                   accept;         // Opcode taken this clock

  localparam logic [15:0] DIV_LAST = 16'(MCYC_CLKS - 1);

  // ==========================================================
  // Length and timing lookup
  ilt_decode u_decode (
    .opcode_in (fetch_in.opcode),
    .oper_in   (fetch_in.oper),
    .dec_out   (dec_now)
  );

  // ==========================================================
  // Machine cycle divider
  always_comb begin
    mcyc_en = (div_ff == DIV_LAST);
    nxt_div = mcyc_en ? 16'h0000 : div_ff + 16'h0001;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // ==========================================================
  // Issue control next state
  always_comb begin
    accept    = fetch_in.vld && ready_ff;
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_pc    = pc_ff;
    nxt_dec   = dec_ff;
    nxt_ready = ready_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      // Waiting for an opcode
      ILT_ST_IDLE: begin
        if (accept) begin
          nxt_dec   = dec_now;
          // Step over all code bytes of this form
          nxt_pc    = pc_ff + ILT_PC_W'(dec_now.len);
          nxt_cnt   = dec_now.cyc;
          nxt_ready = 1'b0;
          nxt_state = ILT_ST_EXEC;
        end
      end
      // Burn the listed machine cycles
      ILT_ST_EXEC: begin
        if (mcyc_en) begin
          if (cnt_ff <= 3'd1) begin
            nxt_done  = 1'b1;
            nxt_ready = 1'b1;
            nxt_state = ILT_ST_IDLE;
            nxt_cnt   = '0;
          end else begin
            nxt_cnt = cnt_ff - 3'd1;
          end
        end
      end
      default: begin
        nxt_state = ILT_ST_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  // Issue control registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= ILT_ST_IDLE;
      cnt_ff   <= '0;
      pc_ff    <= ILT_PC_RESET;
      dec_ff   <= '0;
      ready_ff <= 1'b1;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      pc_ff    <= nxt_pc;
      dec_ff   <= nxt_dec;
      ready_ff <= nxt_ready;
      done_ff  <= nxt_done;
    end
  end

  // Outputs straight from flip-flops
  assign ready_out = ready_ff;
  assign pc_out    = pc_ff;
  assign dec_out   = dec_ff;
  assign done_out  = done_ff;

  // ==========================================================
  // Checks
  logic [ILT_CYC_W-1:0] tick_ff;   // Machine cycles seen in execution
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_ff <= '0;
    end else if (state_ff == ILT_ST_IDLE) begin
      tick_ff <= '0;
    end else if (mcyc_en) begin
      tick_ff <= tick_ff + 3'd1;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_acc_logic_len: assert property (
    accept && fetch_in.opcode inside {8'h58, 8'h46, 8'h6F}
    |=> dec_ff.len == 2'd1 && dec_ff.cyc == 3'd1)
    else $error("accumulator logic form mis-sized");
  a_imm_dir_logic: assert property (
    accept && fetch_in.opcode inside {8'h53, 8'h43, 8'h63}
    |=> dec_ff.len == 2'd3 && dec_ff.cyc == 3'd2)
    else $error("immediate to direct logic mis-sized");
  a_acc_dir_logic: assert property (
    accept && fetch_in.opcode inside {8'h52, 8'h42, 8'h62}
    |=> dec_ff.len == 2'd2 && dec_ff.cyc == 3'd1)
    else $error("accumulator to direct logic mis-sized");
  a_single_acc_op: assert property (
    accept && fetch_in.opcode inside {8'hE4, 8'h23, 8'hC4}
    |=> dec_ff.len == 2'd1 && dec_ff.cyc == 3'd1)
    else $error("accumulator op mis-sized");
  a_reg_dir_move: assert property (
    accept && fetch_in.opcode inside {8'hA9, 8'h8A, 8'h86}
    |=> dec_ff.len == 2'd2 && dec_ff.cyc == 3'd2)
    else $error("register direct move mis-sized");
  a_data_pointer_reg_load: assert property (
    accept && fetch_in.opcode == 8'h90
    |=> pc_ff == $past(pc_ff) + 16'd3 && dec_ff.cyc == 3'd2)
    else $error("data pointer load mis-sized");
  a_ext_ram_move: assert property (
    accept && fetch_in.opcode inside {8'hE0, 8'hF2}
    |=> dec_ff.len == 2'd1 && dec_ff.cyc == 3'd2)
    else $error("external RAM move mis-sized");
  a_acc_self_move: assert property (
    accept && fetch_in.opcode == 8'hE5 && fetch_in.oper == ILT_ACC_SFR
    |=> !dec_ff.valid)
    else $error("accumulator self move accepted");
  a_bit_clear_jmp: assert property (
    accept && fetch_in.opcode == 8'h10
    |=> dec_ff.bit_clr && dec_ff.len == 2'd3)
    else $error("bit jump clear missing");
  a_decrement_jump_nonzero_forms: assert property (
    accept && fetch_in.opcode == 8'hD5
    |=> dec_ff.len == 2'd3 && dec_ff.cyc == 3'd2)
    else $error("direct decrement jump mis-sized");
  a_issue_hold: assert property (
    done_ff |-> tick_ff == $past(dec_ff.cyc))
    else $error("issue released early or late");
  a_ready_low: assert property (
    accept |=> !ready_ff throughout (##[0:1] 1'b1))
    else $error("ready not dropped after accept");

  // ==========================================================
  // Further form checks and issue hold
  // Three-byte direct-direct and immediate-direct moves
  a_dir_dir_move: assert property (
    accept && fetch_in.opcode inside {8'h85, 8'h75}
    |=> dec_ff.len == 2'd3 && dec_ff.cyc == 3'd2)
    else $error("direct move mis-sized");
  // Code memory reads, both bases
  a_code_read: assert property (
    accept && fetch_in.opcode inside {8'h93, 8'h83}
    |=> dec_ff.len == 2'd1 && dec_ff.cyc == 3'd2)
    else $error("code memory read mis-sized");
  // Stack push and pop
  a_push_pop: assert property (
    accept && fetch_in.opcode inside {8'hC0, 8'hD0}
    |=> dec_ff.len == 2'd2 && dec_ff.cyc == 3'd2)
    else $error("push or pop mis-sized");
  // Byte exchanges run in one cycle
  a_xch_cycle: assert property (
    accept && fetch_in.opcode inside {8'hC5, 8'hC9, 8'hC7}
    |=> dec_ff.cyc == 3'd1)
    else $error("byte exchange mis-timed");
  // Nibble exchange is one byte, one cycle
  a_nibble_exchange_len: assert property (
    accept && fetch_in.opcode inside {8'hD6, 8'hD7}
    |=> dec_ff.len == 2'd1 && dec_ff.cyc == 3'd1)
    else $error("nibble exchange mis-sized");
  // Bit logic into carry
  a_carry_logic: assert property (
    accept && fetch_in.opcode inside {8'h82, 8'hB0, 8'h72, 8'hA0}
    |=> dec_ff.len == 2'd2 && dec_ff.cyc == 3'd2)
    else $error("carry bit logic mis-sized");
  // Carry copied into a bit
  a_carry_to_bit: assert property (
    accept && fetch_in.opcode == 8'h92
    |=> dec_ff.len == 2'd2 && dec_ff.cyc == 3'd2)
    else $error("carry to bit mis-sized");
  // Bit copied into carry
  a_bit_to_carry: assert property (
    accept && fetch_in.opcode == 8'hA2
    |=> dec_ff.len == 2'd2 && dec_ff.cyc == 3'd1)
    else $error("bit to carry mis-sized");
  // Indirect jump through the data pointer
  a_ind_jump: assert property (
    accept && fetch_in.opcode == 8'h73
    |=> dec_ff.len == 2'd1 && dec_ff.cyc == 3'd2)
    else $error("indirect jump mis-sized");
  // Compare and jump forms
  a_cmp_jump: assert property (
    accept && fetch_in.opcode inside {8'hB4, 8'hB5, 8'hB6, 8'hBD}
    |=> dec_ff.len == 2'd3 && dec_ff.cyc == 3'd2)
    else $error("compare jump mis-sized");
  // Register decrement jump
  a_decrement_jump_nonzero_reg: assert property (
    accept && fetch_in.opcode inside {[8'hD8:8'hDF]}
    |=> dec_ff.len == 2'd2 && dec_ff.cyc == 3'd2)
    else $error("register decrement jump mis-sized");
  // Accumulator and carry conditional jumps
  a_cond_jump: assert property (
    accept && fetch_in.opcode inside {8'h60, 8'h70, 8'h40, 8'h50}
    |=> dec_ff.len == 2'd2 && dec_ff.cyc == 3'd2)
    else $error("conditional jump mis-sized");
  // Short relative jump
  a_short_jump: assert property (
    accept && fetch_in.opcode == 8'h80
    |=> dec_ff.len == 2'd2 && dec_ff.cyc == 3'd2)
    else $error("short jump mis-sized");
  // Done lasts a single clock
  a_done_pulse: assert property (
    done_ff |=> !done_ff)
    else $error("done held too long");
  // Fetch address and decode hold while an instruction runs
  a_busy_hold: assert property (
    !ready_ff |=> $stable(pc_ff) && $stable(dec_ff))
    else $error("state changed while busy");

  c_two_cycle: cover property (accept && dec_now.cyc == 3'd2 ##[1:40] done_ff);
  c_three_byte: cover property (accept && dec_now.len == 2'd3);
  c_invalid: cover property (accept && dec_now.known && !dec_now.valid);
  c_bit_clear: cover property (accept && dec_now.bit_clr);

endmodule

// ---- ilt_core_bench.sv ----
`timescale 1ns/1ps

module ilt_core_bench;
  import ilt_pkg::*;

  // ==========================================================
  // Bench settings and signals
  localparam int M = 2;  // Short machine cycle keeps the run brief

  typedef struct packed {
    ilt_dec_s    dec;  // Expected decode
    logic [15:0] pc;   // Expected next fetch address
  } ilt_note_s;

  logic        mclk_in     = 1'b0;      // Core clock
  logic        rst_n_in    = 1'b0;      // Reset, active low
  ilt_fetch_s  fetch_in    = '0;        // Opcode request
  logic        ready_out;               // Core can take an opcode
  logic [15:0] pc_out;                  // Next fetch address
  ilt_dec_s    dec_out;                 // Decode in execution
  logic        done_out;                // Cycles elapsed pulse
  ilt_note_s   notes[$];                // Expected results, oldest first
  ilt_note_s   w_note;                  // Note under comparison
  int          w_k;                     // Clocks from accept to done
  logic [15:0] exp_pc      = 16'h0000;  // Model of the fetch address
  logic [31:0] seed        = 32'hE057;  // Random state
  int          miscompares = 0;         // Mismatch count
  int          n_checks    = 0;         // Comparison count

  ilt_core #(
    .MCYC_CLKS (M)
  ) u_ilt_core (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .fetch_in  (fetch_in),
    .ready_out (ready_out),
    .pc_out    (pc_out),
    .dec_out   (dec_out),
    .done_out  (done_out)
  );

  // Free-running clock, 25 ns period
  always #12.5 mclk_in = ~mclk_in;

  // ==========================================================
  // Helpers
  // Xorshift step for stimulus values
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Expected length and timing per opcode
  function automatic ilt_dec_s exp_of(input logic [7:0] op,
                                      input logic [7:0] od);
    ilt_dec_s d;
    d = '{known: 1'b1, valid: 1'b1, len: 2'd1, cyc: 3'd1, bit_clr: 1'b0};
    casez (op)
      8'h53, 8'h43, 8'h63, 8'h85, 8'h75, 8'h90, 8'hB4, 8'hB5, 8'hB6,
      8'hB7, 8'b1011_1???, 8'hD5, 8'h20, 8'h30, 8'h02,
      8'h12 : begin
        d.len = 2'd3;
        d.cyc = 3'd2;
      end
      8'h10 : begin
        d.len = 2'd3;
        d.cyc = 3'd2;
        d.bit_clr = 1'b1;
      end
      8'h55, 8'h45, 8'h65, 8'h54, 8'h44, 8'h64, 8'h52, 8'h42, 8'h62,
      8'hC5, 8'hA2, 8'hE5, 8'h74, 8'b0111_1???, 8'hF5, 8'h76, 8'h77,
      8'hC2, 8'hD2, 8'hB2 : begin
        d.len = 2'd2;
        d.valid = (op != 8'hE5) || (od != ILT_ACC_SFR);
      end
      8'b1010_1???, 8'b1000_1???, 8'hA6, 8'hA7, 8'h86, 8'h87, 8'hC0,
      8'hD0, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'h92, 8'b1101_1???, 8'h60,
      8'h70, 8'h40, 8'h50, 8'h80,
      8'b????_0001 : begin
        d.len = 2'd2;
        d.cyc = 3'd2;
      end
      8'h93, 8'h83, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3,
      8'h22, 8'h32,
      8'h73 : begin
        d.cyc = 3'd2;
      end
      8'b0101_1???, 8'h56, 8'h57, 8'b0100_1???, 8'h46, 8'h47,
      8'b0110_1???, 8'h66, 8'h67, 8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03,
      8'h13, 8'hC4, 8'b1100_1???, 8'hC6, 8'hC7, 8'hD6,
      8'b1110_1???, 8'hE6, 8'hE7, 8'b1111_1???, 8'hF6, 8'hF7,
      8'hC3, 8'hD3, 8'hB3, 8'h00,
      8'hD7 : begin
        d.cyc = 3'd1;
      end
      default : begin
        d.known = 1'b0;
        d.valid = 1'b0;
      end
    endcase
    return d;
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Bound ran out: count it and stop
  task automatic tmo(input string nm);
    miscompares++;
    $display("wrong value %s expected event seen timeout", nm);
    end_sim();
  endtask

  // Outputs at rest while reset is still held low
  task automatic chk_idle;
    chk("ready_out", 32'd1, 32'(ready_out));
    chk("pc_out", 32'(ILT_PC_RESET), 32'(pc_out));
    chk("dec_out", 32'd0, 32'(dec_out));
    chk("done_out", 32'd0, 32'(done_out));
  endtask

  // One request; junk is offered while busy and must be ignored
  task automatic issue(input logic [7:0] op, input logic [7:0] od);
    ilt_note_s n;
    int        k;
    n.dec = exp_of(op, od);
    exp_pc = exp_pc + 16'(n.dec.len);
    n.pc = exp_pc;
    notes.push_back(n);
    k = 0;
    fetch_in = '{vld: 1'b1, opcode: op, oper: od};
    @(posedge mclk_in);
    #2;
    seed = xs(seed);
    fetch_in = '{vld: 1'b1, opcode: seed[7:0], oper: seed[15:8]};
    while (ready_out !== 1'b1 && k < 40) begin
      @(posedge mclk_in);
      #2;
      k++;
    end
    if (k >= 40) tmo("ready_out");
  endtask

  // ==========================================================
  // Result watcher: pops the oldest note at each accept
  always begin
    @(posedge mclk_in);
    if (rst_n_in === 1'b1 && fetch_in.vld && ready_out === 1'b1) begin
      if (notes.size() == 0) begin
        miscompares++;
        $display("wrong value notes expected entry seen empty");
      end else begin
        w_note = notes.pop_front();
        // Look just after the accepting edge, before done can land
        #1;
        chk("dec_out", 32'(w_note.dec), 32'(dec_out));
        chk("pc_out", 32'(w_note.pc), 32'(pc_out));
        chk("ready_out", 32'd0, 32'(ready_out));
        w_k = 0;
        while (done_out !== 1'b1 && w_k < 40) begin
          @(posedge mclk_in);
          #1;
          w_k++;
        end
        if (w_k >= 40) tmo("done_out");
        chk("done_delay", 32'd1,
            32'(w_k >= (int'(w_note.dec.cyc) - 1) * M + 1 &&
                w_k <= int'(w_note.dec.cyc) * M));
        chk("ready_out", 32'd1, 32'(ready_out));
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    ilt_dec_s d;
    repeat (5) @(posedge mclk_in);
    #2;
    chk_idle();
    rst_n_in = 1'b1;
    // Every opcode that the groups list, back to back
    for (int op = 0; op < 256; op++) begin
      seed = xs(seed);
      d = exp_of(op[7:0], seed[7:0]);
      if (d.known || op == 8'h24) issue(op[7:0], seed[7:0]);
    end
    issue(8'hE5, ILT_ACC_SFR);
    issue(8'hE5, 8'hE1);
    fetch_in.vld = 1'b0;
    // Reset in mid-run
    repeat (3) @(posedge mclk_in);
    #2;
    rst_n_in = 1'b0;
    repeat (2) @(posedge mclk_in);
    #2;
    chk_idle();
    rst_n_in = 1'b1;
    exp_pc = ILT_PC_RESET;
    // Random opcode order after the reset
    repeat (80) begin
      seed = xs(seed);
      d = exp_of(seed[15:8], seed[7:0]);
      if (d.known) issue(seed[15:8], seed[7:0]);
    end
    fetch_in.vld = 1'b0;
    repeat (10) @(posedge mclk_in);
    end_sim();
  end

endmodule

// ---- ilt_decode.sv ----
package ilt_pkg;

  // ==========================================================
  // Widths and constants
  localparam int          ILT_PC_W        = 16;     // Program counter width
  localparam int          ILT_LEN_W       = 2;      // Byte count width
  localparam int          ILT_CYC_W       = 3;      // Machine cycle count width
  localparam int          ILT_MCYC_CLKS   = 12;     // Clocks per machine cycle
  localparam logic [7:0]  ILT_ACC_SFR     = 8'hE0;  // Accumulator SFR address
  localparam logic [15:0] ILT_PC_RESET    = 16'h0000; // Start address

  // ==========================================================
  // Fetch request from program memory side
  typedef struct packed {
    logic       vld;     // Opcode bytes present
    logic [7:0] opcode;  // First code byte
    logic [7:0] oper;    // Second code byte
  } ilt_fetch_s;

  // Decoded length and timing
  typedef struct packed {
    logic                 known;     // Opcode in decoded groups
    logic                 valid;     // Legal instruction form
    logic [ILT_LEN_W-1:0] len;       // Code bytes
    logic [ILT_CYC_W-1:0] cyc;       // Machine cycles
    logic                 bit_clr;   // Tested bit cleared if taken
  } ilt_dec_s;

  // Control states
  typedef enum logic {
    ILT_ST_IDLE,
    ILT_ST_EXEC
  } ilt_state_e;

endpackage

`timescale 1ns/1ps

module ilt_decode (
  input  wire logic [7:0]     opcode_in,
  input  wire logic [7:0]     oper_in,
  output ilt_pkg::ilt_dec_s   dec_out
);
  import ilt_pkg::*;

  // ==========================================================
  // Length and cycle lookup
  always_comb begin
    dec_out         = '0;
    dec_out.known   = 1'b1;
    dec_out.valid   = 1'b1;
    dec_out.len     = 2'd1;
    dec_out.cyc     = 3'd1;
    casez (opcode_in)
      // Logic into accumulator, register or indirect source
      8'b0101_1???, 8'b0100_1???, 8'b0110_1???,
      8'b0101_011?, 8'b0100_011?, 8'b0110_011?: begin
        dec_out.len = 2'd1;
      end
      // Logic into accumulator, direct or immediate source
      8'h55, 8'h45, 8'h65, 8'h54, 8'h44, 8'h64: begin
        dec_out.len = 2'd2;
      end
      // Immediate into direct byte
      8'h53, 8'h43, 8'h63: begin
        dec_out.len = 2'd3;
        dec_out.cyc = 3'd2;
      end
      // Accumulator into direct byte
      8'h52, 8'h42, 8'h62: begin
        dec_out.len = 2'd2;
      end
      // Single operand accumulator ops
      8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4: begin
        dec_out.len = 2'd1;
      end
      // Direct source into accumulator
      8'hE5: begin
        dec_out.len   = 2'd2;
        dec_out.valid = (oper_in != ILT_ACC_SFR);
      end
      // One byte, one cycle moves and exchanges
      8'b1110_1???, 8'b1110_011?, 8'b1111_1???, 8'b1111_011?,
      8'b1100_1???, 8'b1100_011?, 8'b1101_011?: begin
        dec_out.len = 2'd1;
      end
      // Two byte, one cycle moves and exchanges
      8'h74, 8'b0111_1???, 8'hF5, 8'b0111_011?, 8'hC5: begin
        dec_out.len = 2'd2;
      end
      // Register or indirect against direct byte
      8'b1010_1???, 8'b1000_1???, 8'b1000_011?, 8'b1010_011?: begin
        dec_out.len = 2'd2;
        dec_out.cyc = 3'd2;
      end
      // Direct to direct, immediate to direct
      8'h85, 8'h75: begin
        dec_out.len = 2'd3;
        dec_out.cyc = 3'd2;
      end
      // Data pointer load, 16-bit constant in trailing bytes
      8'h90: begin
        dec_out.len = 2'd3;
        dec_out.cyc = 3'd2;
      end
      // Code memory reads and indirect jump
      8'h93, 8'h83, 8'h73: begin
        dec_out.cyc = 3'd2;
      end
      // External RAM moves, 8 and 16 bit addressing
      8'b1110_001?, 8'hE0, 8'b1111_001?, 8'hF0: begin
        dec_out.cyc = 3'd2;
      end
      // Returns
      8'h22, 8'h32: begin
        dec_out.cyc = 3'd2;
      end
      // Stack push and pop
      8'hC0, 8'hD0: begin
        dec_out.len = 2'd2;
        dec_out.cyc = 3'd2;
      end
      // Carry and bit logic, and no operation
      8'h82, 8'hB0, 8'h72, 8'hA0: begin
        dec_out.len = 2'd2;
        dec_out.cyc = 3'd2;
      end
      8'h92: begin
        dec_out.len = 2'd2;
        dec_out.cyc = 3'd2;
      end
      8'hA2, 8'hC2, 8'hD2, 8'hB2: begin
        dec_out.len = 2'd2;
      end
      8'hC3, 8'hD3, 8'hB3, 8'h00: begin
        dec_out.len = 2'd1;
      end
      // Bit test jumps, clear variant flagged
      8'h10, 8'h20, 8'h30: begin
        dec_out.len     = 2'd3;
        dec_out.cyc     = 3'd2;
        dec_out.bit_clr = (opcode_in == 8'h10);
      end
      // Compare and jump if unequal
      8'hB5, 8'hB4, 8'b1011_1???, 8'b1011_011?: begin
        dec_out.len = 2'd3;
        dec_out.cyc = 3'd2;
      end
      // Decrement and jump, register form
      8'b1101_1???: begin
        dec_out.len = 2'd2;
        dec_out.cyc = 3'd2;
      end
      // Decrement and jump, direct form; long jump and call
      8'hD5, 8'h02, 8'h12: begin
        dec_out.len = 2'd3;
        dec_out.cyc = 3'd2;
      end
      // Conditional and short relative jumps, absolute jumps and calls
      8'h60, 8'h70, 8'h40, 8'h50, 8'h80, 8'b???0_0001,
      8'b???1_0001: begin
        dec_out.len = 2'd2;
        dec_out.cyc = 3'd2;
      end
      // Groups outside this decoder
      default: begin
        dec_out.known = 1'b0;
        dec_out.valid = 1'b0;
      end
    endcase
  end

endmodule
